// file: tb_top.sv
// Self-checking bench for the two-channel capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`include "tcct_params.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic ch0_i, ch0_o, ch0_oe, ch1_i, ch1_o, ch1_oe, ext_clk, irq_ovf, irq_ch0, irq_ch1;
  int num_errors = 0;
  int total_checks = 0;
  int hi;
  tcct_top u_tcct_top (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CH0_PIN_I(ch0_i), .CH0_PIN_O(ch0_o), .CH0_PIN_OE(ch0_oe), .CH1_PIN_I(ch1_i), .CH1_PIN_O(ch1_o),
    .CH1_PIN_OE(ch1_oe), .EXT_CLK_I(ext_clk), .IRQ_OVF(irq_ovf), .IRQ_CH0(irq_ch0), .IRQ_CH1(irq_ch1));
  tcct_pin_model u_pin_model (.clk(clk), .ch0_o(ch0_o), .ch0_oe(ch0_oe), .ch1_o(ch1_o), .ch1_oe(ch1_oe),
    .ch0_i(ch0_i), .ch1_i(ch1_i), .ext_clk(ext_clk));
  ////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // One APB transfer: setup, access held until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      num_errors++;
    end
    v = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'h0, 32'h0);
  endtask
  // High time of the channel 0 pin over one period of ten counts
  function automatic int high_time();
    return u_pin_model.t_fall > u_pin_model.t_rise ? u_pin_model.t_fall - u_pin_model.t_rise
      : 10 - (u_pin_model.t_rise - u_pin_model.t_fall);
  endfunction
  // Counts and verdict
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog against a hung wait for a request line
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    // Reset values and an unmapped address
    rd(`TCCT_ADDR_SC);
    `CHK("status reset", 32'h20, v)
    `CHK("mapped ok", 1'h0, e)
    rd(`TCCT_ADDR_MOD);
    `CHK("modulo reset", 32'hFFFF, v)
    wr(8'h20, 32'h5);
    `CHK("unmapped error", 1'h1, e)
    // External clock edges counted, reads leave the count alone
    wr(`TCCT_ADDR_SC, 32'h17);
    u_pin_model.ext_pulses(5);
    // Clock enable low freezes the count
    ce <= 1'h0;
    u_pin_model.ext_pulses(2);
    ce <= 1'h1;
    wr(`TCCT_ADDR_SC, 32'h27);
    rd(`TCCT_ADDR_CNT);
    `CHK("ext count", 32'h5, v)
    rd(`TCCT_ADDR_CNT);
    `CHK("count held", 32'h5, v)
    // Modulo wrap, overflow flag and gated request
    wr(`TCCT_ADDR_MOD, 32'h9);
    wr(`TCCT_ADDR_SC, 32'h10);
    repeat (30) @(posedge clk);
    `CHK("ovf gated", 1'h0, irq_ovf)
    wr(`TCCT_ADDR_SC, 32'hC0);
    repeat (2) @(posedge clk);
    `CHK("ovf irq", 1'h1, irq_ovf)
    wr(`TCCT_ADDR_SC, 32'hE0);
    rd(`TCCT_ADDR_CNT);
    `CHK("wrap bound", 1'h1, v <= 32'h9)
    wr(`TCCT_ADDR_SC, 32'h60);
    rd(`TCCT_ADDR_SC);
    `CHK("ovf cleared", 32'h60, v)
    `CHK("ovf irq low", 1'h0, irq_ovf)
    // Toggle on compare at every internal prescale rate
    wr(`TCCT_ADDR_CH0_VAL, 32'h5);
    wr(`TCCT_ADDR_CH0_SC, 32'h14);
    for (int p = 0; p < 7; p++) begin
      wr(`TCCT_ADDR_SC, 32'h10 | p);
      repeat (60 << p) @(posedge clk);
      `CHK("toggle period", 20 << p, u_pin_model.t_rise - u_pin_model.t_rise_prev)
    end
    `CHK("ch0 driven", 1'h1, ch0_oe)
    // Set and clear on compare with toggle on overflow
    wr(`TCCT_ADDR_CH0_VAL, 32'h3);
    for (int a = 2; a < 4; a++) begin
      wr(`TCCT_ADDR_CH0_SC, 32'h12 | (a << 2));
      wr(`TCCT_ADDR_SC, 32'h10);
      repeat (60) @(posedge clk);
      hi = high_time();
      `CHK("pulse high", a == 3 ? 7 : 3, hi)
    end
    // Lower the compare value from the compare handler
    wr(`TCCT_ADDR_CH0_SC, 32'h5E);
    while (irq_ch0 !== 1'h1) @(posedge clk);
    wr(`TCCT_ADDR_CH0_VAL, 32'h2);
    repeat (40) @(posedge clk);
    hi = high_time();
    `CHK("lowered pulse", 8, hi)
    `CHK("ch0 irq", 1'h1, irq_ch0)
    // Raise the compare value from the overflow handler
    wr(`TCCT_ADDR_SC, 32'h40);
    while (irq_ovf !== 1'h1) @(posedge clk);
    wr(`TCCT_ADDR_CH0_VAL, 32'h6);
    repeat (40) @(posedge clk);
    hi = high_time();
    `CHK("raised pulse", 4, hi)
    // Capture on each edge selection with a frozen count of 3
    wr(`TCCT_ADDR_SC, 32'h17);
    u_pin_model.ext_pulses(3);
    wr(`TCCT_ADDR_SC, 32'h27);
    for (int s = 1; s < 4; s++) begin
      wr(`TCCT_ADDR_CH1_VAL, 32'h0);
      wr(`TCCT_ADDR_CH1_SC, 32'h40 | (s << 2));
      u_pin_model.ev1 <= 1'h1;
      repeat (4) @(posedge clk);
      `CHK("rise event", s[0], irq_ch1)
      wr(`TCCT_ADDR_CH1_SC, 32'h40 | (s << 2));
      u_pin_model.ev1 <= 1'h0;
      repeat (4) @(posedge clk);
      `CHK("fall event", s[1], irq_ch1)
      rd(`TCCT_ADDR_CH1_VAL);
      `CHK("capture value", 32'h3, v)
    end
    // Linked compare: last written set takes over at overflow
    wr(`TCCT_ADDR_CH0_VAL, 32'h5);
    wr(`TCCT_ADDR_CH0_SC, 32'h3C);
    wr(`TCCT_ADDR_SC, 32'h10);
    repeat (30) @(posedge clk);
    rd(`TCCT_ADDR_CH0_SC);
    `CHK("active set 0", 1'h0, v[8])
    wr(`TCCT_ADDR_CH1_VAL, 32'h7);
    repeat (30) @(posedge clk);
    rd(`TCCT_ADDR_CH0_SC);
    `CHK("active set 1", 1'h1, v[8])
    `CHK("ch0 linked drive", 1'h1, ch0_oe)
    `CHK("ch1 irq unused", 1'h0, irq_ch1)
    `CHK("ch1 released", 1'h0, ch1_oe)
    // Channel 1 pin as general-purpose output while linked
    wr(`TCCT_ADDR_GPIO, 32'hA);
    repeat (2) @(posedge clk);
    `CHK("gpio drive", 2'h3, {ch1_oe, ch1_o})
    rd(`TCCT_ADDR_GPIO);
    `CHK("gpio input", 1'h1, v[5])
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: tcct_edge_detect.sv
// Input capture edge detector for one channel pin
`timescale 1ns/10ps
`default_nettype none
module tcct_edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic [1:0] sel,
  output logic event_o
);
  tcct_pkg::tcct_edge_state_type st_r;
  tcct_pkg::tcct_edge_state_type st_nxt;

  // edge select, bit 0 rising, bit 1 falling
  always_comb begin
    st_nxt.prev = pin;
    event_o = (sel[0] && pin && !st_r.prev) || (sel[1] && !pin && st_r.prev);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tcct_params.svh
// Register offsets, field positions, reset values of the two-channel capture/compare timer
`ifndef TCCT_PARAMS_SVH
`define TCCT_PARAMS_SVH
`define TCCT_ADDR_SC 8'h00
`define TCCT_ADDR_CNT 8'h04
`define TCCT_ADDR_MOD 8'h08
`define TCCT_ADDR_CH0_SC 8'h0C
`define TCCT_ADDR_CH0_VAL 8'h10
`define TCCT_ADDR_CH1_SC 8'h14
`define TCCT_ADDR_CH1_VAL 8'h18
`define TCCT_ADDR_GPIO 8'h1C
`define TCCT_SC_OVF 7
`define TCCT_SC_OIE 6
`define TCCT_SC_STOP 5
`define TCCT_SC_TRST 4
`define TCCT_SC_PS_HI 2
`define TCCT_CH_FLAG 7
`define TCCT_CH_IE 6
`define TCCT_CH_MSB 5
`define TCCT_CH_MSA 4
`define TCCT_CH_ELSB 3
`define TCCT_CH_ELSA 2
`define TCCT_CH_TOV 1
`define TCCT_PS_EXT 3'h7
`define TCCT_RST_MOD 16'hFFFF
`define TCCT_RST_STOP 1'h1
`endif

// file: tcct_pin_model.sv
// Far-side model of the timer pins: event sources, external clock, pin monitor
`timescale 1ns/10ps
`default_nettype none
module tcct_pin_model (
  input wire logic clk,
  input wire logic ch0_o,
  input wire logic ch0_oe,
  input wire logic ch1_o,
  input wire logic ch1_oe,
  output logic ch0_i,
  output logic ch1_i,
  output logic ext_clk
);
  logic ev0 = 1'h0;
  logic ev1 = 1'h0;
  logic prev0 = 1'h0;
  int cyc = 0;
  int t_rise_prev = 0;
  int t_rise = 0;
  int t_fall = 0;
  initial ext_clk = 1'h0;
  ////////////////////////////////////////////////////////////////////////
  // Shared pin level: the timer's drive wins, else the outside source
  // shared pin level
  assign ch0_i = ch0_oe ? ch0_o : ev0;
  assign ch1_i = ch1_oe ? ch1_o : ev1;
  // Time stamps of channel 0 pin edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev0 <= ch0_i;
    if (ch0_i && !prev0) begin
      t_rise_prev <= t_rise;
      t_rise <= cyc;
    end
    if (!ch0_i && prev0) begin
      t_fall <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // External clock burst; the line stays low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'h1;
      repeat (2) @(posedge clk);
      ext_clk <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: tcct_pkg.sv
// Types shared by the capture/compare timer modules
`default_nettype none
package tcct_pkg;
  typedef enum logic [2:0] {TCCT_OFF = 3'h1, TCCT_IC = 3'h2, TCCT_OC = 3'h4} tcct_mode_type;
  typedef struct packed {
    logic [5:0] pre;
    logic ext_prev;
  } tcct_pre_state_type;
  typedef struct packed {
    logic prev;
  } tcct_edge_state_type;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] mod;
    logic [1:0][15:0] val;
    logic [1:0][7:0] sc;
    logic ovf_f;
    logic ovf_ie;
    logic stop;
    logic [2:0] ps;
    logic [1:0] pin;
    logic [1:0] gp_dat;
    logic [1:0] gp_dir;
    logic act;
    logic last_wr;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [1:0] po;
    logic [1:0] poe;
    logic irq_ovf;
    logic [1:0] irq;
  } tcct_state_type;
endpackage
`default_nettype wire

// file: tcct_prescaler.sv
// Counter clock prescaler with external clock option
`timescale 1ns/10ps
`default_nettype none
`include "tcct_params.svh"
module tcct_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic hold,
  input wire logic [2:0] sel,
  input wire logic ext_clk,
  output logic tick
);
  tcct_pkg::tcct_pre_state_type st_r;
  tcct_pkg::tcct_pre_state_type st_nxt;
  logic [5:0] mask;

  always_comb begin
    mask = ~(6'h3F << sel);
    st_nxt = st_r;
    st_nxt.ext_prev = ext_clk;
    if (sel == `TCCT_PS_EXT) begin
      tick = !hold && ext_clk && !st_r.ext_prev;
    end else begin
      tick = !hold && ((st_r.pre & mask) == mask);
    end
    if (clr) begin
      st_nxt.pre = 6'h00;
    end else if (!hold) begin
      st_nxt.pre = st_r.pre + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tcct_top.sv
// Two-channel capture/compare timer with APB register access
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tcct_params.svh"
module tcct_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CH0_PIN_I,
  output logic CH0_PIN_O,
  output logic CH0_PIN_OE,
  input wire logic CH1_PIN_I,
  output logic CH1_PIN_O,
  output logic CH1_PIN_OE,
  input wire logic EXT_CLK_I,
  output logic IRQ_OVF,
  output logic IRQ_CH0,
  output logic IRQ_CH1
);
  tcct_pkg::tcct_state_type st_r;
  tcct_pkg::tcct_state_type st_nxt;
  tcct_pkg::tcct_mode_type mode [2];
  logic acc;
  logic wr;
  logic rst_wr;
  logic tick;
  logic cnt_en;
  logic ovf_ev;
  logic link;
  logic [15:0] cnt_nx;
  logic [15:0] cmpv [2];
  logic [1:0] pin_i;
  logic [1:0] cap_ev;
  logic [1:0] match;
  logic [31:0] rd;
  logic mapped;

  // Channel operating mode from its status/control byte
  function automatic tcct_pkg::tcct_mode_type chan_mode(input logic [7:0] sc, input logic ch0, input logic lnk);
    tcct_pkg::tcct_mode_type m;
    m = tcct_pkg::TCCT_OFF;
    if (!ch0 && lnk) begin
      m = tcct_pkg::TCCT_OFF;
    end else if (ch0 && sc[`TCCT_CH_MSB]) begin
      m = tcct_pkg::TCCT_OC;
    end else if (sc[`TCCT_CH_MSA]) begin
      m = tcct_pkg::TCCT_OC;
    end else if (sc[`TCCT_CH_ELSB] || sc[`TCCT_CH_ELSA]) begin
      m = tcct_pkg::TCCT_IC;
    end
    return m;
  endfunction

  assign pin_i = {CH1_PIN_I, CH0_PIN_I};

  ////////////////////////////////////////////////////////////////////////////////
  // prescaled counter clock
  tcct_prescaler u_pre (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .clr(rst_wr),
    .hold(st_r.stop),
    .sel(st_r.ps),
    .ext_clk(EXT_CLK_I),
    .tick(tick)
  );

  tcct_edge_detect u_edge0 (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pin(CH0_PIN_I),
    .sel(st_r.sc[0][`TCCT_CH_ELSB:`TCCT_CH_ELSA]),
    .event_o(cap_ev[0])
  );
  tcct_edge_detect u_edge1 (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pin(CH1_PIN_I),
    .sel(st_r.sc[1][`TCCT_CH_ELSB:`TCCT_CH_ELSA]),
    .event_o(cap_ev[1])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus access, counter, channels, pins
  always_comb begin
    st_nxt = st_r;
    acc = PSEL && PENABLE && st_r.ready;
    wr = acc && PWRITE;
    rst_wr = wr && (PADDR == `TCCT_ADDR_SC) && PWDATA[`TCCT_SC_TRST];
    link = st_r.sc[0][`TCCT_CH_MSB];
    cnt_en = tick && !rst_wr;
    ovf_ev = cnt_en && (st_r.cnt == st_r.mod);
    cnt_nx = ovf_ev ? 16'h0000 : st_r.cnt + 16'h0001;
    rd = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      `TCCT_ADDR_SC: rd = {24'h00_0000, st_r.ovf_f, st_r.ovf_ie, st_r.stop, 2'h0, st_r.ps};
      `TCCT_ADDR_CNT: rd = {16'h0000, st_r.cnt};
      `TCCT_ADDR_MOD: rd = {16'h0000, st_r.mod};
      `TCCT_ADDR_CH0_SC: rd = {23'h00_0000, st_r.act, st_r.sc[0]};
      `TCCT_ADDR_CH0_VAL: rd = {16'h0000, st_r.val[0]};
      `TCCT_ADDR_CH1_SC: rd = {24'h00_0000, st_r.sc[1]};
      `TCCT_ADDR_CH1_VAL: rd = {16'h0000, st_r.val[1]};
      `TCCT_ADDR_GPIO: rd = {25'h000_0000, EXT_CLK_I, pin_i, st_r.gp_dir, st_r.gp_dat};
      default: mapped = 1'b0;
    endcase
    // APB answer one cycle into the access phase
    if (PSEL && PENABLE && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = PWRITE ? st_r.rdata : rd;
      st_nxt.slverr = !mapped;
    end else begin
      st_nxt.ready = 1'b0;
      st_nxt.slverr = 1'b0;
    end
    // Register writes; writing 0 to a flag clears it
    if (wr) begin
      case (PADDR)
        `TCCT_ADDR_SC: begin
          st_nxt.ovf_ie = PWDATA[`TCCT_SC_OIE];
          st_nxt.stop = PWDATA[`TCCT_SC_STOP];
          st_nxt.ps = PWDATA[`TCCT_SC_PS_HI:0];
          if (!PWDATA[`TCCT_SC_OVF]) begin
            st_nxt.ovf_f = 1'b0;
          end
        end
        `TCCT_ADDR_MOD: st_nxt.mod = PWDATA[15:0];
        `TCCT_ADDR_CH0_SC, `TCCT_ADDR_CH1_SC: begin
          st_nxt.sc[PADDR == `TCCT_ADDR_CH1_SC][`TCCT_CH_IE:`TCCT_CH_TOV] = PWDATA[`TCCT_CH_IE:`TCCT_CH_TOV];
          if (!PWDATA[`TCCT_CH_FLAG]) begin
            st_nxt.sc[PADDR == `TCCT_ADDR_CH1_SC][`TCCT_CH_FLAG] = 1'b0;
          end
        end
        // new compare value applies at once unless written to the inactive set of a linked pair, which waits for overflow
        `TCCT_ADDR_CH0_VAL, `TCCT_ADDR_CH1_VAL: begin
          st_nxt.val[PADDR[3]] = PWDATA[15:0];
          st_nxt.last_wr = PADDR[3];
        end
        `TCCT_ADDR_GPIO: begin
          st_nxt.gp_dat = PWDATA[1:0];
          st_nxt.gp_dir = PWDATA[3:2];
        end
        default: st_nxt.gp_dat = st_r.gp_dat;
      endcase
    end
    if (rst_wr) begin
      st_nxt.cnt = 16'h0000;
    end else if (cnt_en) begin
      st_nxt.cnt = cnt_nx;
    end
    if (ovf_ev) begin
      st_nxt.ovf_f = 1'b1;
    end
    if (!link) begin
      st_nxt.act = 1'b0;
    end else if (ovf_ev) begin
      st_nxt.act = st_r.last_wr;
    end
    for (int i = 0; i < 2; i++) begin
      mode[i] = chan_mode(st_r.sc[i], i == 0, link);
      // linked pair compares the active set
      cmpv[i] = (i == 0 && link && st_r.act) ? st_r.val[1] : st_r.val[i];
      match[i] = (mode[i] == tcct_pkg::TCCT_OC) && cnt_en && (cnt_nx == cmpv[i]);
      case (mode[i])
        tcct_pkg::TCCT_IC: begin
          if (cap_ev[i]) begin
            // capture wins over a bus write
            st_nxt.val[i] = st_r.cnt;
            st_nxt.sc[i][`TCCT_CH_FLAG] = 1'b1;
          end
        end
        tcct_pkg::TCCT_OC: begin
          if (ovf_ev && st_r.sc[i][`TCCT_CH_TOV]) begin
            st_nxt.pin[i] = !st_r.pin[i];
          end
          if (match[i]) begin
            st_nxt.sc[i][`TCCT_CH_FLAG] = 1'b1;
            case (st_r.sc[i][`TCCT_CH_ELSB:`TCCT_CH_ELSA])
              2'h1: st_nxt.pin[i] = !st_nxt.pin[i];
              2'h2: st_nxt.pin[i] = 1'b0;
              2'h3: st_nxt.pin[i] = 1'b1;
              default: st_nxt.pin[i] = st_nxt.pin[i];
            endcase
          end
        end
        default: st_nxt.pin[i] = st_r.pin[i];
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      case (chan_mode(st_nxt.sc[i], i == 0, st_nxt.sc[0][`TCCT_CH_MSB]))
        tcct_pkg::TCCT_OC: begin
          st_nxt.po[i] = (st_nxt.sc[i][`TCCT_CH_ELSB:`TCCT_CH_ELSA] != 2'h0) ? st_nxt.pin[i] : st_nxt.gp_dat[i];
          st_nxt.poe[i] = (st_nxt.sc[i][`TCCT_CH_ELSB:`TCCT_CH_ELSA] != 2'h0) || st_nxt.gp_dir[i];
        end
        tcct_pkg::TCCT_IC: begin
          st_nxt.po[i] = st_nxt.gp_dat[i];
          st_nxt.poe[i] = 1'b0;
        end
        default: begin
          // linked channel 1 or idle pin is GPIO
          st_nxt.po[i] = st_nxt.gp_dat[i];
          st_nxt.poe[i] = st_nxt.gp_dir[i];
        end
      endcase
      st_nxt.irq[i] = st_nxt.sc[i][`TCCT_CH_FLAG] && st_nxt.sc[i][`TCCT_CH_IE];
    end
    // channel 1 request silent while linked
    if (st_nxt.sc[0][`TCCT_CH_MSB]) begin
      st_nxt.irq[1] = 1'b0;
    end
    st_nxt.irq_ovf = st_nxt.ovf_f && st_nxt.ovf_ie;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, frozen while CE is low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.mod <= `TCCT_RST_MOD;
      st_r.stop <= `TCCT_RST_STOP;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign PRDATA = st_r.rdata;
  assign PREADY = st_r.ready;
  assign PSLVERR = st_r.slverr;
  assign CH0_PIN_O = st_r.po[0];
  assign CH0_PIN_OE = st_r.poe[0];
  assign CH1_PIN_O = st_r.po[1];
  assign CH1_PIN_OE = st_r.poe[1];
  assign IRQ_OVF = st_r.irq_ovf;
  assign IRQ_CH0 = st_r.irq[0];
  assign IRQ_CH1 = st_r.irq[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the time base, channels and requests
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_count_up;
    CE && cnt_en && !ovf_ev |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not advance by one");

  property p_wrap;
    CE && ovf_ev |=> st_r.cnt == 16'h0000 && st_r.ovf_f;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap with overflow flag");

  property p_stop_hold;
    CE && st_r.stop && !rst_wr |=> $stable(st_r.cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_reset_bit;
    CE && rst_wr |=> st_r.cnt == 16'h0000;
  endproperty
  a_reset_bit: assert property (p_reset_bit) else $error("reset bit did not clear counter");

  property p_capture;
    CE && mode[1] == tcct_pkg::TCCT_IC && cap_ev[1] |=> st_r.val[1] == $past(st_r.cnt) && st_r.sc[1][7];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost counter value or flag");

  property p_set_action;
    CE && match[0] && st_r.sc[0][3:2] == 2'h3 |=> st_r.pin[0] && CH0_PIN_O;
  endproperty
  a_set_action: assert property (p_set_action) else $error("compare set action failed");

  property p_handover;
    CE && link && ovf_ev |=> st_r.act == $past(st_r.last_wr);
  endproperty
  a_handover: assert property (p_handover) else $error("buffered set not handed over");

  property p_ch_irq;
    IRQ_CH0 == (st_r.sc[0][7] && st_r.sc[0][6]);
  endproperty
  a_ch_irq: assert property (p_ch_irq) else $error("channel request without enabled flag");

  property p_ovf_irq;
    CE && ovf_ev && st_r.ovf_ie && !wr |=> IRQ_OVF;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

  property p_linked_pin1;
    CE && st_r.sc[0][5] |-> CH1_PIN_OE == st_r.gp_dir[1] && CH1_PIN_O == st_r.gp_dat[1];
  endproperty
  a_linked_pin1: assert property (p_linked_pin1) else $error("linked channel 1 pin not GPIO");

  c_overflow: cover property (CE && ovf_ev);
  c_capture: cover property (CE && cap_ev[1] && mode[1] == tcct_pkg::TCCT_IC);
  c_handover: cover property (CE && link && ovf_ev && st_r.last_wr);
endmodule
`default_nettype wire
